// [hdl/dft_regs.vh]
/*
  Register offsets, field positions, reset values and masks for the DMA FIFO
  test and status register bank.
  Assumes inclusion by bare name from the design files of this block only.
*/
`ifndef DFT_REGS_VH
`define DFT_REGS_VH

// ----------------------------------------------------------------------------
// Register offsets on the byte-wide internal register port
// ----------------------------------------------------------------------------
`define DFT_OFF_ARB_PRIORITY 8'h18
`define DFT_OFF_FIFO_LANE_FLAGS 8'h19
`define DFT_OFF_DMA_SIGNAL_STATUS 8'h1A
`define DFT_OFF_FIFO_CONTROL_REVISION 8'h1B
`define DFT_OFF_RETURN_POINTER 8'h1C
`define DFT_OFF_BYTE_OFFSET_LOW 8'h20

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DFT_ARB_PRIORITY_MSB 2
`define DFT_BIT_DIRECTION 7
`define DFT_BIT_SIGNAL_PROCESS 6
`define DFT_BIT_IO_SPACE 5
`define DFT_BIT_MEM_SPACE 4
`define DFT_BIT_SCRATCH_MODE 3
`define DFT_BIT_TRUE_EOP 2
`define DFT_BIT_DATA_REQUEST 1
`define DFT_BIT_DATA_ACK 0
`define DFT_BIT_FLUSH 3
`define DFT_BIT_CLEAR 2
`define DFT_BIT_FETCH_MODE 1
`define DFT_BIT_WRITE_INVALIDATE 0

// ----------------------------------------------------------------------------
// Reset values and residual masks
// ----------------------------------------------------------------------------
`define DFT_RST_ARB_PRIORITY 3'h0
`define DFT_RST_LANE_FLAGS 8'hF0
`define DFT_RST_SIGNAL_STATUS 8'h01
`define DFT_RST_BYTE_OFFSET 10'h000
`define DFT_MASK_SMALL_FIFO 10'h07F
`define DFT_MASK_LARGE_FIFO 10'h3FF

`endif

// [hdl/dft_byte_counter.v]
/*
  Byte offset counter between the SCSI core and the DMA core, with the
  residual byte count left in the DMA FIFO.
  Assumes step inputs and the host byte counter come from logic on ref_clk.
*/
`timescale 1ns/1ps
`include "dft_regs.vh"

module dft_byte_counter (
  input wire ref_clk,
  input wire rstn,
  input wire soft_reset,
  input wire low_wr,
  input wire [7:0] low_wdata,
  input wire high_wr,
  input wire [1:0] high_wdata,
  input wire step_valid,
  input wire [3:0] step_bytes,
  input wire [9:0] host_byte_counter,
  input wire fifo_size_select,
  output reg [9:0] count,
  output reg [9:0] residual
);

  wire [9:0] next_count;
  wire [9:0] mask;

  // Advance by bytes moved; software writes win over a step
  // Count moves only on core transfer steps and software writes, so it is stable once both stop
  assign next_count = low_wr ? {count[9:8], low_wdata} :
                      high_wr ? {high_wdata, count[7:0]} :
                      step_valid ? count + {6'h00, step_bytes} : count;

  // Seven-bit mask for the small FIFO, ten-bit for the large one
  assign mask = fifo_size_select ? `DFT_MASK_LARGE_FIFO : `DFT_MASK_SMALL_FIFO;

  // Counter and residual registers
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      count <= `DFT_RST_BYTE_OFFSET;
      residual <= `DFT_RST_BYTE_OFFSET;
    end else if (soft_reset) begin
      count <= `DFT_RST_BYTE_OFFSET;
      residual <= `DFT_RST_BYTE_OFFSET;
    end else begin
      count <= next_count;
      // Residual is offset minus host count, masked
      residual <= (count - host_byte_counter) & mask;
    end
  end

endmodule // dft_byte_counter

// [hdl/dft_return_pointer.v]
/*
  Return pointer register: byte writable, captured on call, handed to the
  instruction pointer on return, frozen during memory-to-memory moves.
  Assumes call and return strobes are one-cycle pulses on ref_clk.
*/
`timescale 1ns/1ps

module dft_return_pointer (
  input wire ref_clk,
  input wire rstn,
  input wire [3:0] byte_wr,
  input wire [7:0] wdata,
  input wire call_exec,
  input wire [31:0] call_return_addr,
  input wire return_exec,
  input wire mem_move_active,
  output reg [31:0] pointer,
  output reg ret_load,
  output reg [31:0] ret_value
);

  genvar i;

  // Per-byte update; the move freezes both call capture and writes
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_byte
      // Power-up value is undefined, so a zero reset is a safe choice
      always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
          pointer[i*8+7:i*8] <= 8'h00;
        end else if (mem_move_active) begin
          pointer[i*8+7:i*8] <= pointer[i*8+7:i*8];
        end else if (call_exec) begin
          pointer[i*8+7:i*8] <= call_return_addr[i*8+7:i*8];
        end else if (byte_wr[i]) begin
          pointer[i*8+7:i*8] <= wdata;
        end
      end
    end
  endgenerate

  // Return loads the held pointer into the instruction pointer
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ret_load <= 1'b0;
      ret_value <= 32'h00000000;
    end else begin
      ret_load <= return_exec;
      if (return_exec) begin
        ret_value <= pointer;
      end
    end
  end

endmodule // dft_return_pointer

// [hdl/dft_status_regs.v]
/*
  DMA FIFO test, status and control register bank of one SCSI function.
  Holds arbitration priority, FIFO lane flags, handshake mirrors, FIFO
  flush and clear control, fetch pin mode, write-and-invalidate use, the
  return pointer and the core-to-core byte offset counter.
  Assumes a byte-wide internal register port and that every status input
  comes from logic on ref_clk, so none of them is synchronised here.
*/
// Behaviour
// - Three-bit arbiter priority in lowest bits, zero lowest, seven highest, resets zero.
// - Four read-only lane-empty bits; all set means empty; all set after reset.
// - Four read-only lane-full bits; all set means full; clear after reset.
// - Direction bit reads one for SCSI-to-host, zero for host-to-SCSI.
// - Copy of signal-process flag at bit 6; reading register clears original.
// - Two read-only bits show I/O space and memory space enables.
// - Scratch mode makes scratch B show RAM base, scratch A register base.
// - Bits mirror true-end-of-process and data-request, one when active.
// - Data-acknowledge bit reads one while active-low acknowledge inactive; one after reset.
// - Upper nibble of fourth register shows revision, equal to PCI revision low nibble.
// - Flush bit moves FIFO data to memory from next-address pointer, per direction.
// - Clear bit resets FIFO pointers, then self-clears; bottom word stays.
// - Fetch mode: fetch output only during opcode; else every fetch cycle.
// - Write-and-invalidate only when local and configuration enables both set.
// - Return pointer captures call return address; return loads instruction pointer.
// - Return pointer unchanged across memory-to-memory moves; power-up undefined.
// - Ten-bit byte offset counter counts core-to-core bytes; resets zero.
// - Counter may change during transfers, stable once transfer stopped.
// - FIFO residual is offset minus host count, masked 7Fh or 3FFh.
// - Host may write signal-process flag anytime; observed and cleared via copy.
// - Asserted DMA write signal means SCSI-to-host data flow.
// - FIFO-size select gives 88 or 536 byte depth; resets clear.
`timescale 1ns/1ps
`include "dft_regs.vh"

module dft_status_regs (
  input wire ref_clk,
  input wire rstn,
  input wire soft_reset,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata,
  input wire [3:0] lane_empty_flags,
  input wire [3:0] lane_full_flags,
  input wire dma_write_direction,
  input wire signal_process_flag,
  input wire io_space_enabled,
  input wire memory_space_enabled,
  input wire true_end_of_process,
  input wire data_request_status,
  input wire data_ack_n,
  input wire [7:0] pci_revision_id,
  input wire [31:0] ram_base_address,
  input wire [31:0] op_reg_base_address,
  input wire [31:0] scratch_a_value,
  input wire [31:0] scratch_b_value,
  input wire fifo_clear_done,
  input wire fetch_cycle,
  input wire opcode_phase,
  input wire pci_mwi_enable,
  input wire mwi_legal,
  input wire call_exec,
  input wire [31:0] call_return_addr,
  input wire return_exec,
  input wire mem_move_active,
  input wire offset_high_wr,
  input wire [1:0] offset_high_wdata,
  input wire core_xfer_valid,
  input wire [3:0] core_xfer_bytes,
  input wire [9:0] host_byte_counter,
  input wire fifo_size_select,
  output reg [2:0] arb_priority_field,
  output reg signal_process_clear,
  output reg scratch_base_mode,
  output reg [31:0] scratch_reg_a,
  output reg [31:0] scratch_reg_b,
  output reg fifo_flush,
  output reg flush_to_host,
  output reg fifo_clear,
  output reg fetch_n,
  output reg use_write_invalidate,
  output reg [31:0] return_pointer,
  output reg return_load,
  output reg [31:0] return_ip_value,
  output reg [9:0] fifo_byte_offset_counter,
  output reg [9:0] fifo_residual
);

  // --------------------------------------------------------------------------
  // Clear sequencer states
  // --------------------------------------------------------------------------
  localparam CLR_IDLE = 2'b01;
  localparam CLR_BUSY = 2'b10;

  // --------------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------------
  // Decode shared by the write and read paths
  function hit;
    input [7:0] addr;
    input [7:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  reg [7:0] lane_flags;
  reg [7:0] signal_status;
  reg fetch_pin_mode;
  reg write_invalidate_enable;
  reg [1:0] clr_state;
  reg [1:0] next_clr_state;
  reg [7:0] next_rdata;
  reg [3:0] rp_byte_wr;
  wire [31:0] rp_pointer;
  wire rp_load;
  wire [31:0] rp_value;
  wire [9:0] boc_count;
  wire [9:0] boc_residual;
  wire wr_ctrl;
  wire rd_status;
  wire [3:0] revision_level;

  assign wr_ctrl = reg_wr & hit(reg_addr, `DFT_OFF_FIFO_CONTROL_REVISION);
  assign rd_status = reg_rd & hit(reg_addr, `DFT_OFF_DMA_SIGNAL_STATUS);
  // Revision nibble tracks the PCI revision identifier low nibble
  assign revision_level = pci_revision_id[3:0];

  // Byte strobes into the return pointer, little-endian within the word
  always @* begin
    rp_byte_wr = 4'h0;
    if (reg_wr && (reg_addr & 8'hFC) == `DFT_OFF_RETURN_POINTER) begin
      rp_byte_wr[reg_addr[1:0]] = 1'b1;
    end
  end

  // --------------------------------------------------------------------------
  // Status mirrors
  // --------------------------------------------------------------------------
  // Mirrors are flopped so reset shows documented defaults before the FIFO
  // logic settles; the cost is one cycle of lag on every status bit.
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      lane_flags <= `DFT_RST_LANE_FLAGS;
      signal_status <= `DFT_RST_SIGNAL_STATUS;
    end else if (soft_reset) begin
      lane_flags <= `DFT_RST_LANE_FLAGS;
      signal_status <= `DFT_RST_SIGNAL_STATUS;
    end else begin
      // Empty lanes in the high nibble, full lanes in the low
      lane_flags <= {lane_empty_flags, lane_full_flags};
      // Direction follows the DMA write signal
      signal_status[`DFT_BIT_DIRECTION] <= dma_write_direction;
      // Copy of the host-writable signal-process flag
      signal_status[`DFT_BIT_SIGNAL_PROCESS] <= signal_process_flag;
      signal_status[`DFT_BIT_IO_SPACE] <= io_space_enabled;
      signal_status[`DFT_BIT_MEM_SPACE] <= memory_space_enabled;
      signal_status[`DFT_BIT_SCRATCH_MODE] <= 1'b0;
      signal_status[`DFT_BIT_TRUE_EOP] <= true_end_of_process;
      signal_status[`DFT_BIT_DATA_REQUEST] <= data_request_status;
      // Active-low acknowledge shown as is, so inactive reads one
      signal_status[`DFT_BIT_DATA_ACK] <= data_ack_n;
    end
  end

  // --------------------------------------------------------------------------
  // Writable control fields
  // --------------------------------------------------------------------------
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      arb_priority_field <= `DFT_RST_ARB_PRIORITY;
      scratch_base_mode <= 1'b0;
      fifo_flush <= 1'b0;
      fetch_pin_mode <= 1'b0;
      write_invalidate_enable <= 1'b0;
    end else if (soft_reset) begin
      arb_priority_field <= `DFT_RST_ARB_PRIORITY;
      scratch_base_mode <= 1'b0;
      fifo_flush <= 1'b0;
      fetch_pin_mode <= 1'b0;
      write_invalidate_enable <= 1'b0;
    end else begin
      // Priority field in the low three bits, upper bits ignored
      if (reg_wr && hit(reg_addr, `DFT_OFF_ARB_PRIORITY)) begin
        arb_priority_field <= reg_wdata[`DFT_ARB_PRIORITY_MSB:0];
      end
      // Only the scratch-mode bit takes a write here
      if (reg_wr && hit(reg_addr, `DFT_OFF_DMA_SIGNAL_STATUS)) begin
        scratch_base_mode <= reg_wdata[`DFT_BIT_SCRATCH_MODE];
      end
      // Flush holds until software writes it back to zero
      if (wr_ctrl) begin
        fifo_flush <= reg_wdata[`DFT_BIT_FLUSH];
        fetch_pin_mode <= reg_wdata[`DFT_BIT_FETCH_MODE];
        write_invalidate_enable <= reg_wdata[`DFT_BIT_WRITE_INVALIDATE];
      end
    end
  end

  // --------------------------------------------------------------------------
  // FIFO clear sequencer
  // --------------------------------------------------------------------------
  // Clear stays set until the FIFO reports its pointers are cleared
  always @* begin
    next_clr_state = clr_state;
    case (clr_state)
      CLR_IDLE: begin
        if (wr_ctrl && reg_wdata[`DFT_BIT_CLEAR]) begin
          next_clr_state = CLR_BUSY;
        end
      end
      CLR_BUSY: begin
        if (fifo_clear_done) begin
          next_clr_state = CLR_IDLE;
        end
      end
      default: begin
        next_clr_state = CLR_IDLE;
      end
    endcase
  end

  // Sequencer state and the clear request it drives
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      clr_state <= CLR_IDLE;
      fifo_clear <= 1'b0;
    end else if (soft_reset) begin
      clr_state <= CLR_IDLE;
      fifo_clear <= 1'b0;
    end else begin
      clr_state <= next_clr_state;
      // Self-clears; bottom data word is not touched from here
      fifo_clear <= (next_clr_state == CLR_BUSY);
    end
  end

  // --------------------------------------------------------------------------
  // Derived outputs
  // --------------------------------------------------------------------------
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fetch_n <= 1'b1;
      use_write_invalidate <= 1'b0;
      flush_to_host <= 1'b0;
      signal_process_clear <= 1'b0;
      scratch_reg_a <= 32'h00000000;
      scratch_reg_b <= 32'h00000000;
    end else begin
      // Opcode-only fetch strobe in fetch mode, whole fetch otherwise
      if (fetch_pin_mode) begin
        fetch_n <= ~(fetch_cycle & opcode_phase);
      end else begin
        fetch_n <= ~fetch_cycle;
      end
      // Both enables and a legal point are needed
      use_write_invalidate <= write_invalidate_enable & pci_mwi_enable & mwi_legal;
      // Flush direction comes from the DMA write signal; the flush
      // engine starts from the next-address pointer it already owns
      flush_to_host <= dma_write_direction;
      // Reading the status register clears the original flag
      signal_process_clear <= rd_status;
      // Scratch views switch to the base addresses in scratch mode
      if (scratch_base_mode) begin
        scratch_reg_a <= op_reg_base_address;
        scratch_reg_b <= ram_base_address;
      end else begin
        scratch_reg_a <= scratch_a_value;
        scratch_reg_b <= scratch_b_value;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Return pointer and byte offset counter
  // --------------------------------------------------------------------------
  // Writes during script execution are not guarded here; software keeps off
  dft_return_pointer u_return_pointer (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .byte_wr(rp_byte_wr),
    .wdata(reg_wdata),
    .call_exec(call_exec),
    .call_return_addr(call_return_addr),
    .return_exec(return_exec),
    .mem_move_active(mem_move_active),
    .pointer(rp_pointer),
    .ret_load(rp_load),
    .ret_value(rp_value)
  );

  dft_byte_counter u_byte_counter (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .soft_reset(soft_reset),
    .low_wr(reg_wr & hit(reg_addr, `DFT_OFF_BYTE_OFFSET_LOW)),
    .low_wdata(reg_wdata),
    .high_wr(offset_high_wr),
    .high_wdata(offset_high_wdata),
    .step_valid(core_xfer_valid),
    .step_bytes(core_xfer_bytes),
    .host_byte_counter(host_byte_counter),
    .fifo_size_select(fifo_size_select),
    .count(boc_count),
    .residual(boc_residual)
  );

  // Re-flop the submodule results so every top output leaves a local flop
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      return_pointer <= 32'h00000000;
      return_load <= 1'b0;
      return_ip_value <= 32'h00000000;
      fifo_byte_offset_counter <= `DFT_RST_BYTE_OFFSET;
      fifo_residual <= `DFT_RST_BYTE_OFFSET;
    end else begin
      return_pointer <= rp_pointer;
      // Return hands the pointer to the instruction pointer
      return_load <= rp_load;
      return_ip_value <= rp_value;
      // Counter and residual for the selected FIFO size
      fifo_byte_offset_counter <= boc_count;
      fifo_residual <= boc_residual;
    end
  end

  // --------------------------------------------------------------------------
  // Read path
  // --------------------------------------------------------------------------
  // Unmapped offsets read zero; reserved priority bits read zero too
  always @* begin
    next_rdata = 8'h00;
    case (reg_addr)
      `DFT_OFF_ARB_PRIORITY: next_rdata = {5'h00, arb_priority_field};
      `DFT_OFF_FIFO_LANE_FLAGS: next_rdata = lane_flags;
      `DFT_OFF_DMA_SIGNAL_STATUS: next_rdata = signal_status | {4'h0, scratch_base_mode, 3'h0};
      `DFT_OFF_FIFO_CONTROL_REVISION: next_rdata = {revision_level, fifo_flush, fifo_clear,
                                                    fetch_pin_mode, write_invalidate_enable};
      8'h1C: next_rdata = rp_pointer[7:0];
      8'h1D: next_rdata = rp_pointer[15:8];
      8'h1E: next_rdata = rp_pointer[23:16];
      8'h1F: next_rdata = rp_pointer[31:24];
      `DFT_OFF_BYTE_OFFSET_LOW: next_rdata = boc_count[7:0];
      default: next_rdata = 8'h00;
    endcase
  end

  // Read data lands one cycle after the read strobe and then holds
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

endmodule // dft_status_regs

// [testbench/dft_status_regs_properties.sv]
/*
  Concurrent checks on the ports of the DMA FIFO test and status register bank.
  Assumes it is bound to dft_status_regs; one clock, asynchronous active-low reset.
*/
`timescale 1ns/1ps
module dft_status_props (
  input wire ref_clk,
  input wire rstn,
  input wire [7:0] reg_addr,
  input wire reg_rd,
  input wire signal_process_clear,
  input wire fetch_cycle,
  input wire opcode_phase,
  input wire fetch_n,
  input wire pci_mwi_enable,
  input wire mwi_legal,
  input wire use_write_invalidate,
  input wire return_exec,
  input wire return_load,
  input wire [31:0] return_ip_value,
  input wire [31:0] return_pointer,
  input wire mem_move_active,
  input wire fifo_clear,
  input wire fifo_clear_done
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // Status read strobe, kept as a net so $past sees one signal
  wire rd_status = reg_rd && (reg_addr == 8'h1A);
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  signal_process_flag_clear_a: assert property (
    rd_status |=> signal_process_clear)
    else $error("status read gave no flag clear");
  signal_process_flag_cause_a: assert property (
    signal_process_clear |-> $past(rd_status))
    else $error("flag clear without status read");
  fetch_idle_a: assert property (
    !$past(fetch_cycle) |-> fetch_n)
    else $error("fetch strobe outside a fetch");
  fetch_opcode_a: assert property (
    $past(fetch_cycle) && $past(opcode_phase) |-> !fetch_n)
    else $error("fetch strobe missing in opcode part");
  mwi_gate_a: assert property (
    use_write_invalidate |-> $past(pci_mwi_enable) && $past(mwi_legal))
    else $error("write and invalidate without enables");
  ret_load_a: assert property (
    return_exec |-> ##2 (return_load && return_ip_value == return_pointer))
    else $error("return did not load pointer");
  move_hold_a: assert property (
    mem_move_active && $past(mem_move_active) && $past(mem_move_active, 2) |-> $stable(return_pointer))
    else $error("return pointer moved during move");
  clear_done_a: assert property (
    fifo_clear && fifo_clear_done |-> ##[1:2] !fifo_clear)
    else $error("clear bit stuck after done");
  // Main scenarios reached
  cover property (rd_status ##1 signal_process_clear);
  cover property (return_load);
  cover property (fifo_clear && fifo_clear_done);
endmodule // dft_status_props

bind dft_status_regs dft_status_props u_props (.*);

// [testbench/testbench.sv]
/*
  Self-checking bench for the DMA FIFO test and status register bank.
  Assumes the bank and its bound checker are compiled first; the bench drives every input.
*/
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'h0, rstn = 1'h0, soft_reset = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, pci_revision_id = 8'h5C;
  logic [3:0] lane_empty_flags = 4'hF, lane_full_flags = 4'h0, core_xfer_bytes = 4'h0;
  logic dma_write_direction = 1'h0, signal_process_flag = 1'h0, io_space_enabled = 1'h0;
  logic memory_space_enabled = 1'h0, true_end_of_process = 1'h0, data_request_status = 1'h0;
  logic data_ack_n = 1'h1, fifo_clear_done = 1'h0, fetch_cycle = 1'h0, opcode_phase = 1'h0;
  logic pci_mwi_enable = 1'h0, mwi_legal = 1'h0, call_exec = 1'h0, return_exec = 1'h0;
  logic mem_move_active = 1'h0, offset_high_wr = 1'h0, core_xfer_valid = 1'h0, fifo_size_select = 1'h0;
  logic [1:0] offset_high_wdata = 2'h0;
  logic [9:0] host_byte_counter = 10'h000;
  logic [31:0] ram_base_address = 32'hA000_0000, op_reg_base_address = 32'hB000_0000;
  logic [31:0] scratch_a_value = 32'h0000_00AA, scratch_b_value = 32'h0000_00BB;
  logic [31:0] call_return_addr = 32'h0000_0000, seen_ip = 32'h0000_0000;
  logic [5:0] pat [4] = '{6'h2A, 6'h15, 6'h3F, 6'h00};
  wire [7:0] reg_rdata;
  wire [2:0] arb_priority_field;
  wire signal_process_clear, scratch_base_mode, fifo_flush, flush_to_host, fifo_clear, fetch_n;
  wire use_write_invalidate, return_load;
  wire [31:0] scratch_reg_a, scratch_reg_b, return_pointer, return_ip_value;
  wire [9:0] fifo_byte_offset_counter, fifo_residual;
  int n_fail = 0;
  int comparisons = 0;
  int n_sclr = 0;

  dft_status_regs dut (.*);

  // Clock; watchdog far beyond the two hundred or so cycles the tests need
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  initial begin
    #2000000;
    n_fail++;
    results();
  end
  // One-cycle pulses: latch the return value, count the flag clears
  always @(posedge ref_clk) begin
    if (return_load) seen_ip <= return_ip_value;
    if (signal_process_clear) n_sclr <= n_sclr + 1;
  end
  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'h1;
    @(negedge ref_clk);
    reg_wr = 1'h0;
  endtask
  // Read data lands one edge after the strobe and then holds
  task rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd = 1'h1;
    @(negedge ref_clk);
    reg_rd = 1'h0;
    @(negedge ref_clk);
    v = reg_rdata;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task results();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [7:0] d;
    cyc(16);
    rstn = 1'h1;
    rd(8'h18, d);
    chk("arb", 8'h00, d & 8'h07);
    rd(8'h19, d);
    chk("lanes", 8'hF0, d);
    rd(8'h1A, d);
    chk("stat", 8'h01, d);
    rd(8'h20, d);
    chk("bol", 8'h00, d);
    // Every priority, reserved bits written high
    for (int p = 0; p < 8; p++) begin
      wr(8'h18, 8'hF8 | 8'(p));
      rd(8'h18, d);
      chk("arb", p, d & 8'h07);
      chk("arbo", p, arb_priority_field);
    end
    soft_reset = 1'h1;
    cyc(1);
    soft_reset = 1'h0;
    rd(8'h18, d);
    chk("soft", 8'h00, d & 8'h07);
    lane_empty_flags = 4'hA;
    lane_full_flags = 4'h5;
    wr(8'h19, 8'h00);
    rd(8'h19, d);
    chk("lanes", 8'hA5, d);
    // Mirrored status patterns
    for (int i = 0; i < 4; i++) begin
      {dma_write_direction, io_space_enabled, memory_space_enabled} = pat[i][5:3];
      {true_end_of_process, data_request_status, data_ack_n} = pat[i][2:0];
      rd(8'h1A, d);
      chk("stat", {pat[i][5], 1'h0, pat[i][4:3], 1'h0, pat[i][2:0]}, d);
    end
    signal_process_flag = 1'h1;
    rd(8'h1A, d);
    chk("signal_process_flag", 8'h40, d);
    chk("sclr", 6, n_sclr);
    signal_process_flag = 1'h0;
    rd(8'h1A, d);
    chk("signal_process_flag", 8'h00, d);
    wr(8'h1A, 8'h08);
    cyc(2);
    chk("scrb", ram_base_address, scratch_reg_b);
    chk("scra", op_reg_base_address, scratch_reg_a);
    rd(8'h1A, d);
    chk("smode", 8'h08, d);
    wr(8'h1A, 8'h00);
    cyc(2);
    chk("scrb", scratch_b_value, scratch_reg_b);
    wr(8'h1B, 8'hF0);
    rd(8'h1B, d);
    chk("rev", 8'hC0, d);
    dma_write_direction = 1'h1;
    wr(8'h1B, 8'h08);
    cyc(10);
    chk("flush", 2'h3, {fifo_flush, flush_to_host});
    wr(8'h1B, 8'h00);
    cyc(2);
    chk("flush", 1'h0, fifo_flush);
    wr(8'h1B, 8'h04);
    rd(8'h1B, d);
    chk("clr", 8'hC4, d);
    fifo_clear_done = 1'h1;
    cyc(1);
    fifo_clear_done = 1'h0;
    cyc(2);
    rd(8'h1B, d);
    chk("clr", 8'hC0, d);
    // Fetch strobe and write-invalidate over mode and input combinations
    fetch_cycle = 1'h1;
    mwi_legal = 1'h1;
    for (int i = 0; i < 4; i++) begin
      wr(8'h1B, {6'h00, i[1], i[1]});
      opcode_phase = i[0];
      pci_mwi_enable = i[0];
      cyc(2);
      chk("fetch", i[1] & ~i[0], fetch_n);
      chk("mwi", i[1] & i[0], use_write_invalidate);
    end
    fetch_cycle = 1'h0;
    call_return_addr = 32'h1234_5678;
    call_exec = 1'h1;
    cyc(1);
    call_exec = 1'h0;
    cyc(2);
    chk("ret", 32'h1234_5678, return_pointer);
    rd(8'h1D, d);
    chk("retb", 8'h56, d);
    return_exec = 1'h1;
    cyc(1);
    return_exec = 1'h0;
    cyc(4);
    chk("rip", 32'h1234_5678, seen_ip);
    // Call capture blocked during a move
    mem_move_active = 1'h1;
    cyc(2);
    call_return_addr = 32'hCAFE_F00D;
    call_exec = 1'h1;
    cyc(1);
    call_exec = 1'h0;
    cyc(2); // no pointer write during a move
    cyc(2);
    mem_move_active = 1'h0;
    chk("move", 32'h1234_5678, return_pointer);
    wr(8'h1C, 8'hAB);
    cyc(2);
    chk("retw", 32'h1234_56AB, return_pointer);
    // Counter preset to 3F0h against host count 010h
    wr(8'h20, 8'hF0);
    offset_high_wdata = 2'h3;
    offset_high_wr = 1'h1;
    cyc(1);
    offset_high_wr = 1'h0;
    host_byte_counter = 10'h010;
    cyc(4);
    chk("boc", 10'h3F0, fifo_byte_offset_counter);
    chk("res", 10'h060, fifo_residual);
    fifo_size_select = 1'h1;
    cyc(4);
    chk("res", 10'h3E0, fifo_residual);
    core_xfer_bytes = 4'h4;
    core_xfer_valid = 1'h1;
    cyc(5);
    core_xfer_valid = 1'h0;
    cyc(4);
    chk("boc", 10'h004, fifo_byte_offset_counter);
    chk("res", 10'h3F4, fifo_residual);
    rd(8'h20, d);
    chk("bol", 8'h04, d);
    results();
  end
endmodule // testbench
